// file: rtl/vhn_defs.svh
// Purpose: constants for the voice activity hangover and noise estimate block
// Assumes: 10 MHz pclk, one frame strobe per 20 ms frame, Q15 speeds, Q8 ratios
// Notes: threshold and speed figures are plain defaults, tune per codec build
// What this block does
// - keep final flag high until hang length zero frames follow a full burst
// - pick high-noise burst and hang lengths when noise sum exceeds threshold
// - timer past limit and short complex count: load long complex hangover
// - low frame power clears all hangover counters and forces flag zero
// - complex count nonzero: burst to high-noise length, count down, flag one
// - ten zero decisions of eleven plus high correlation: flag one
// - positive decision: count burst, load hang at burst length, flag one
// - zero decision: clear burst, count hang down, flag one while it lasts
// - noise estimate follows band levels of the previous frame
// - choose noise up/down speeds from histories, stationarity, complex hangover
// - per band pick up or down speed and blend estimate toward level
// - clamp each noise estimate between noise minimum and maximum
// - stationarity ratio sums max over min of averaged and current levels
// - complex warning raises stationarity counter to its complex minimum
// - reload stationarity counter on quiet, pitch, tone runs or high ratio
// - otherwise a positive decision counts the stationarity counter down
// - averaged level speed is one, active or quiet speed
// - interim decision is one when snr measure exceeds threshold
// - complex timer counts frames of high correlation, else clears
// - complex warning after 15 low or 8 high consecutive flags
`ifndef VHN_DEFS_SVH
`define VHN_DEFS_SVH

`define VHN_NB 9
`define VHN_LW 16
`define VHN_CW 8

`define VHN_ADDR_CTRL 8'h00
`define VHN_ADDR_STATUS 8'h04
`define VHN_ADDR_COUNT 8'h08

`define VHN_HANG_NOISE_THR 20'h00800
`define VHN_BURST_LEN_HIGH 8'h04
`define VHN_HANG_LEN_HIGH 8'h07
`define VHN_BURST_LEN_LOW 8'h05
`define VHN_HANG_LEN_LOW 8'h04
`define VHN_POW_LOW 32'h0000F000
`define VHN_TIMER_LIMIT 16'h0064
`define VHN_TAIL_LENGTH 8'h64
`define VHN_CORR_HANG_THR 16'h6000
`define VHN_CORR_NOISE_THR 16'h5000
`define VHN_LOW_RUN 8'h0F
`define VHN_HIGH_RUN 8'h08

`define VHN_ONE 16'h8000
`define VHN_UP1 16'h0666
`define VHN_DOWN1 16'h1000
`define VHN_UP2 16'h0080
`define VHN_DOWN2 16'h0666
`define VHN_FALL3 16'h0666
`define VHN_AVE_QUIET 16'h1999
`define VHN_AVE_ACTIVE 16'h0666

`define VHN_NOISE_MIN 16'h0028
`define VHN_NOISE_MAX 16'h4000
`define VHN_NOISE_INIT 16'h0028
`define VHN_AVE_INIT 16'h0028
`define VHN_STAT_LEVEL 16'h00B8
`define VHN_STAT_THR 28'h0000F00
`define VHN_STAT_INIT 8'h14
`define VHN_STAT_MIN_CX 8'h05

`endif

// file: rtl/vhn_pkg.sv
// Purpose: shared types of the hangover and noise estimate block
// Assumes: constants come from vhn_defs.svh
// Notes: band index 0 holds the lowest band
`include "vhn_defs.svh"
package vhn_pkg;
   typedef logic [`VHN_NB-1:0][`VHN_LW-1:0] vhn_bands_t;

   typedef struct packed {
      vhn_bands_t level;
      logic [31:0] power;
      logic [31:0] snr_measure;
      logic [31:0] snr_threshold;
      logic [15:0] filtered_highband_correlation;
      logic pitch;
      logic tone;
      logic complex_low;
      logic complex_high;
   } vhn_frame_t;
endpackage

// file: rtl/vhn_band_update.sv
// Purpose: per-band noise estimate, averaged level and stationarity term
// Assumes: Q15 speeds with 16'h8000 as 1.0
// Notes: purely combinational, one instance per band
`timescale 1ns/1ps
`include "vhn_defs.svh"
module vhn_band_update (
   input wire logic [15:0] noise,
   input wire logic [15:0] level_prev,
   input wire logic [15:0] level,
   input wire logic [15:0] ave,
   input wire logic [15:0] speed_up,
   input wire logic [15:0] speed_down,
   input wire logic [15:0] speed_ave,
   output logic [15:0] next_noise,
   output logic [15:0] next_ave,
   output logic [23:0] ratio_term
);
   function automatic logic signed [17:0] blend(input logic [15:0] x, input logic [15:0] t,
                                                input logic [15:0] a);
      logic signed [17:0] d;
      logic signed [34:0] p;
      d = $signed({2'b00, t}) - $signed({2'b00, x});
      p = 35'(d * $signed({1'b0, a}));
      return $signed({2'b00, x}) + p[32:15];
   endfunction

   logic [15:0] speed;
   logic signed [17:0] raw;
   logic [15:0] hi;
   logic [15:0] lo;
   logic [15:0] hi_f;
   logic [15:0] lo_f;
   logic signed [17:0] ave_raw;

   always_comb begin
      speed = (noise < level_prev) ? speed_up : speed_down;
      raw = blend(noise, level_prev, speed);
      if (raw < $signed({2'b00, `VHN_NOISE_MIN})) begin
         next_noise = `VHN_NOISE_MIN;
      end else if (raw > $signed({2'b00, `VHN_NOISE_MAX})) begin
         next_noise = `VHN_NOISE_MAX;
      end else begin
         next_noise = raw[15:0];
      end
      // result lies between ave and level, so the low 16 bits never overflow
      ave_raw = blend(ave, level, speed_ave);
      next_ave = ave_raw[15:0];
      hi = (ave > level) ? ave : level;
      lo = (ave > level) ? level : ave;
      hi_f = (hi > `VHN_STAT_LEVEL) ? hi : `VHN_STAT_LEVEL;
      lo_f = (lo > `VHN_STAT_LEVEL) ? lo : `VHN_STAT_LEVEL;
      ratio_term = {hi_f, 8'h00} / {8'h00, lo_f};
   end
endmodule // vhn_band_update

// file: rtl/vhn_top.sv
// Purpose: final activity flag with hangover, and background noise tracking
// Assumes: frame parameters stable while frame_strobe is high for one cycle
// Notes: all frame state advances in the strobe cycle; APB slave, no wait state
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "vhn_defs.svh"
module vhn_top #(
   parameter int NB = `VHN_NB,
   parameter logic [15:0] NOISE_START = `VHN_NOISE_INIT,
   parameter logic [15:0] AVE_START = `VHN_AVE_INIT
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic frame_strobe,
   input wire vhn_pkg::vhn_frame_t frame,
   output logic vad_flag,
   output logic frame_done,
   output logic complex_warning
);
   localparam logic [7:0] CMAX = 8'hFF;

   logic enable;
   logic fs;
   logic vadreg;
   logic [10:0] vad_hist;
   logic [3:0] pitch_hist;
   logic [4:0] tone_hist;
   logic [10:0] next_vad_hist;
   logic [3:0] next_pitch_hist;
   logic [4:0] next_tone_hist;
   logic [7:0] burst_count;
   logic [7:0] hang_count;
   logic [7:0] cx_count;
   logic [15:0] cx_timer;
   logic [7:0] stat_count;
   logic [7:0] low_run;
   logic [7:0] high_run;
   logic low_power;

   logic [7:0] next_burst;
   logic [7:0] next_hang;
   logic [7:0] next_cx_count;
   logic [15:0] next_cx_timer;
   logic [7:0] cx_loaded;
   logic next_flag;
   logic [7:0] next_stat;
   logic [7:0] stat_raised;
   logic [7:0] next_low_run;
   logic [7:0] next_high_run;
   logic next_warning;
   logic [7:0] burst_len;
   logic [7:0] hang_len;
   logic [7:0] burst_inc;
   logic [19:0] noise_level;
   logic [27:0] stat_ratio;
   logic [15:0] up_speed;
   logic [15:0] down_speed;
   logic [15:0] ave_speed;

   vhn_pkg::vhn_bands_t noise_est;
   vhn_pkg::vhn_bands_t ave_level;
   vhn_pkg::vhn_bands_t prev_level;
   vhn_pkg::vhn_bands_t next_noise;
   vhn_pkg::vhn_bands_t next_ave;
   logic [NB-1:0][23:0] ratio_term;

   // strobes are ignored while software holds the block disabled
   assign fs = frame_strobe & enable;
   assign vadreg = frame.snr_measure > frame.snr_threshold;
   assign next_vad_hist = {vad_hist[9:0], vadreg};
   assign next_pitch_hist = {pitch_hist[2:0], frame.pitch};
   assign next_tone_hist = {tone_hist[3:0], frame.tone};
   assign low_power = frame.power < `VHN_POW_LOW;

   // one slice per band, all sharing this frame's speed choice
   genvar b;
   generate
      for (b = 0; b < NB; b++) begin : g_band
         vhn_band_update u_band (
            .noise(noise_est[b]),
            .level_prev(prev_level[b]),
            .level(frame.level[b]),
            .ave(ave_level[b]),
            .speed_up(up_speed),
            .speed_down(down_speed),
            .speed_ave(ave_speed),
            .next_noise(next_noise[b]),
            .next_ave(next_ave[b]),
            .ratio_term(ratio_term[b])
         );
      end
   endgenerate

   always_comb begin
      noise_level = 20'h00000;
      stat_ratio = 28'h0000000;
      for (int i = 0; i < NB; i++) begin
         noise_level = noise_level + 20'(noise_est[i]);
         stat_ratio = stat_ratio + 28'(ratio_term[i]);
      end
   end

   // lengths follow the noise sum from before this frame's update
   always_comb begin
      if (noise_level > `VHN_HANG_NOISE_THR) begin
         burst_len = `VHN_BURST_LEN_HIGH;
         hang_len = `VHN_HANG_LEN_HIGH;
      end else begin
         burst_len = `VHN_BURST_LEN_LOW;
         hang_len = `VHN_HANG_LEN_LOW;
      end
   end

   // complex timer and warning runs
   always_comb begin
      if (frame.filtered_highband_correlation > `VHN_CORR_HANG_THR) begin
         next_cx_timer = (cx_timer == 16'hFFFF) ? cx_timer : cx_timer + 16'h0001;
      end else begin
         next_cx_timer = 16'h0000;
      end
      next_low_run = frame.complex_low ? ((low_run == CMAX) ? low_run : low_run + 8'h01) : 8'h00;
      next_high_run = frame.complex_high ? ((high_run == CMAX) ? high_run : high_run + 8'h01)
                                         : 8'h00;
      next_warning = (next_low_run >= `VHN_LOW_RUN) || (next_high_run >= `VHN_HIGH_RUN);
      if ((next_cx_timer > `VHN_TIMER_LIMIT) && (cx_count < `VHN_TAIL_LENGTH)) begin
         cx_loaded = `VHN_TAIL_LENGTH;
      end else begin
         cx_loaded = cx_count;
      end
   end

   // hangover decision, first matching branch ends the frame's decision
   always_comb begin
      next_burst = burst_count;
      next_hang = hang_count;
      next_cx_count = cx_loaded;
      next_flag = 1'b0;
      burst_inc = (burst_count == CMAX) ? burst_count : burst_count + 8'h01;
      if (low_power) begin
         next_burst = 8'h00;
         next_hang = 8'h00;
         next_cx_count = 8'h00;
      end else if (cx_loaded != 8'h00) begin
         next_burst = `VHN_BURST_LEN_HIGH;
         next_cx_count = cx_loaded - 8'h01;
         next_flag = 1'b1;
      end else if ((next_vad_hist[10:1] == 10'h000) &&
                   (frame.filtered_highband_correlation > `VHN_CORR_NOISE_THR)) begin
         next_flag = 1'b1;
      end else if (vadreg) begin
         next_burst = burst_inc;
         if (burst_inc >= burst_len) begin
            next_hang = hang_len;
         end
         next_flag = 1'b1;
      end else begin
         next_burst = 8'h00;
         if (hang_count != 8'h00) begin
            next_hang = hang_count - 8'h01;
            next_flag = 1'b1;
         end
      end
   end

   // speeds use the stationarity count from before this frame's update
   always_comb begin
      if ((next_vad_hist[3:0] == 4'h0) && (next_pitch_hist == 4'h0) &&
          (cx_loaded == 8'h00)) begin
         up_speed = `VHN_UP1;
         down_speed = `VHN_DOWN1;
      end else if ((stat_count == 8'h00) && (cx_loaded == 8'h00)) begin
         up_speed = `VHN_UP2;
         down_speed = `VHN_DOWN2;
      end else begin
         up_speed = 16'h0000;
         down_speed = `VHN_FALL3;
      end
   end

   always_comb begin
      if (complex_warning && (stat_count < `VHN_STAT_MIN_CX)) begin
         stat_raised = `VHN_STAT_MIN_CX;
      end else begin
         stat_raised = stat_count;
      end
      if ((next_vad_hist[7:0] == 8'h00) || (next_pitch_hist[1:0] == 2'b11) ||
          (next_tone_hist == 5'h1F) || (stat_ratio > `VHN_STAT_THR)) begin
         next_stat = `VHN_STAT_INIT;
      end else if (vadreg && (stat_raised != 8'h00)) begin
         next_stat = stat_raised - 8'h01;
      end else begin
         next_stat = stat_raised;
      end
      if (next_stat == `VHN_STAT_INIT) begin
         ave_speed = `VHN_ONE;
      end else if (vadreg) begin
         ave_speed = `VHN_AVE_ACTIVE;
      end else begin
         ave_speed = `VHN_AVE_QUIET;
      end
   end

   // low power also drops the timer so a stale count cannot reload a long tail
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burst_count <= 8'h00;
         hang_count <= 8'h00;
         cx_count <= 8'h00;
         cx_timer <= 16'h0000;
         vad_flag <= 1'b0;
      end else if (fs) begin
         burst_count <= next_burst;
         hang_count <= next_hang;
         cx_count <= next_cx_count;
         cx_timer <= low_power ? 16'h0000 : next_cx_timer;
         vad_flag <= next_flag;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vad_hist <= 11'h000;
         pitch_hist <= 4'h0;
         tone_hist <= 5'h00;
         low_run <= 8'h00;
         high_run <= 8'h00;
         complex_warning <= 1'b0;
         stat_count <= 8'h00;
      end else if (fs) begin
         vad_hist <= next_vad_hist;
         pitch_hist <= next_pitch_hist;
         tone_hist <= next_tone_hist;
         low_run <= next_low_run;
         high_run <= next_high_run;
         complex_warning <= next_warning;
         stat_count <= next_stat;
      end
   end

   // prev_level holds last frame's bands: the update lags so speech onsets stay out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         noise_est <= {NB{NOISE_START}};
         ave_level <= {NB{AVE_START}};
         prev_level <= '0;
      end else if (fs) begin
         noise_est <= next_noise;
         ave_level <= next_ave;
         prev_level <= frame.level;
      end
   end

   // done trails the strobe by one cycle, when the new flag already stands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_done <= 1'b0;
      end else begin
         frame_done <= fs;
      end
   end

   // apb: data is latched in setup, so every access completes in one access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (paddr == `VHN_ADDR_CTRL) begin
            prdata <= {31'h00000000, enable};
         end else if (paddr == `VHN_ADDR_STATUS) begin
            prdata <= {16'h0000, stat_count, 4'h0, complex_warning, vad_hist[0],
                       cx_count != 8'h00, vad_flag};
         end else if (paddr == `VHN_ADDR_COUNT) begin
            prdata <= {burst_count, hang_count, cx_count, cx_timer[7:0]};
         end else begin
            pslverr <= 1'b1;
         end
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // enable resets high so frames flow before software touches the block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable <= 1'b1;
      end else if (psel && penable && pready && pwrite && (paddr == `VHN_ADDR_CTRL)) begin
         enable <= pwdata[0];
      end
   end
endmodule // vhn_top

// file: bench/vhn_front_end.sv
// Purpose: front end model that presents one frame per request
// Assumes: req is a one-cycle pulse from the bench
// Notes: frame lines churn outside the strobe cycle so late sampling shows up
`timescale 1ns/1ps
module vhn_front_end (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req,
   input wire vhn_pkg::vhn_frame_t req_frame,
   output logic frame_strobe,
   output vhn_pkg::vhn_frame_t frame
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_strobe <= 1'b0;
         frame <= '0;
      end else if (req) begin
         frame_strobe <= 1'b1;
         frame <= req_frame;
      end else begin
         frame_strobe <= 1'b0;
         frame <= ~frame;
      end
   end
endmodule // vhn_front_end

// file: bench/vhn_top_assertions.sv
// Purpose: port level checks of the hangover block
// Assumes: enable bit tracked from apb writes to offset 0
// Notes: bound to every vhn_top instance
`timescale 1ns/1ps
`include "vhn_defs.svh"
module vhn_top_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic frame_strobe,
   input wire vhn_pkg::vhn_frame_t frame,
   input wire logic vad_flag,
   input wire logic frame_done,
   input wire logic complex_warning
);
   logic en;
   logic [3:0] hi_run;
   wire acc = frame_strobe && en;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) en <= 1'b1;
      else if (psel && penable && pready && pwrite && paddr == 8'h00) en <= pwdata[0];
   end
   // saturate so a long run never wraps back below the warning count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) hi_run <= 4'h0;
      else if (acc && !frame.complex_high) hi_run <= 4'h0;
      else if (acc && hi_run != 4'hF) hi_run <= hi_run + 4'h1;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_pulse;
      frame_done ##1 !frame_done;
   endsequence
   AST_DONE_NEXT: assert property (acc |=> frame_done)
      else $error("frame done missing after accepted strobe");
   AST_DONE_PULSE: assert property (acc ##1 !acc |-> s_pulse)
      else $error("frame done pulse missing");
   AST_NO_DONE: assert property (!acc |=> !frame_done)
      else $error("frame done without accepted strobe");
   AST_FLAG_HOLD: assert property (!acc |=> $stable(vad_flag))
      else $error("activity flag moved between frames");
   AST_WARN_HOLD: assert property (!acc |=> $stable(complex_warning))
      else $error("complex warning moved between frames");
   AST_LOW_POWER: assert property (acc && frame.power < `VHN_POW_LOW |=> !vad_flag)
      else $error("low power frame flagged active");
   AST_SPEECH: assert property (acc && frame.power >= `VHN_POW_LOW
      && frame.snr_measure > frame.snr_threshold |=> vad_flag)
      else $error("positive decision not flagged active");
   AST_WARN_HIGH: assert property (acc && frame.complex_high && hi_run >= 4'h7
      |=> complex_warning)
      else $error("complex warning missing after high run");
   AST_READY: assert property (s_setup |=> pready && penable)
      else $error("apb ready not in first access cycle");
   AST_ERR: assert property (pslverr |-> pready && paddr != `VHN_ADDR_CTRL
      && paddr != `VHN_ADDR_STATUS && paddr != `VHN_ADDR_COUNT)
      else $error("apb error outside unmapped access");
endmodule // vhn_top_assertions
bind vhn_top vhn_top_assertions vhn_top_assertions_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_strobe(frame_strobe),
   .frame(frame), .vad_flag(vad_flag), .frame_done(frame_done),
   .complex_warning(complex_warning));

// file: bench/tb_top.sv
// Purpose: self-checking bench of the hangover and noise block
// Assumes: zero wait state apb slave, front end model feeds frames
// Notes: snr figures are driven directly so noise state only moves lengths
`timescale 1ns/1ps
`include "vhn_defs.svh"
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, frame_strobe, vad_flag, frame_done, complex_warning, e;
   logic req = 1'b0;
   vhn_pkg::vhn_frame_t frame;
   vhn_pkg::vhn_frame_t req_frame = '0;
   logic [31:0] hi_pow = 32'h00100000;
   logic [31:0] lo_pow = 32'h00000100;
   logic [15:0] lv = 16'h0028;
   logic [2:0] ptl = 3'b000;
   int errors = 0;
   int tests_run = 0;
   always #50 pclk = ~pclk;
   vhn_top vhn_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_strobe(frame_strobe), .frame(frame), .vad_flag(vad_flag),
      .frame_done(frame_done), .complex_warning(complex_warning));
   vhn_front_end vhn_front_end_inst (.pclk(pclk), .presetn(presetn), .req(req),
      .req_frame(req_frame), .frame_strobe(frame_strobe), .frame(frame));
   task automatic give_verdict;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic do_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic send(input logic [31:0] pw, input logic d, input logic [15:0] c,
      input logic h);
      @(posedge pclk);
      req_frame <= '{level: {`VHN_NB{lv}}, power: pw, snr_measure: {30'h0, d, 1'b0},
         snr_threshold: 32'h1, filtered_highband_correlation: c, pitch: ptl[2],
         tone: ptl[1], complex_low: ptl[0], complex_high: h};
      req <= 1'b1;
      @(posedge pclk);
      req <= 1'b0;
   endtask
   task automatic fr(input logic [31:0] pw, input logic d, input logic [15:0] c,
      input logic h);
      send(pw, d, c, h);
      repeat (2) @(posedge pclk);
      check(frame_done, 1'b1);
   endtask
   task automatic t_regs;
      apb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, 8'h08, 32'hFFFFFFFF);
      apb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      check(e, 1'b1);
      check(rd, 32'h0);
   endtask
   task automatic t_burst;
      fr(hi_pow, 1'b0, 16'h0, 1'b0);
      apb(1'b0, 8'h04, 32'h0);
      check(rd[15:8], `VHN_STAT_INIT);
      fr(hi_pow, 1'b1, 16'h0, 1'b0);
      apb(1'b0, 8'h04, 32'h0);
      check(rd[15:8], `VHN_STAT_INIT - 8'h01);
      repeat (3) fr(hi_pow, 1'b1, 16'h0, 1'b0);
      fr(hi_pow, 1'b0, 16'h0, 1'b0);
      check(vad_flag, 1'b0);
      repeat (5) fr(hi_pow, 1'b1, 16'h0, 1'b0);
      check(vad_flag, 1'b1);
      repeat (4) begin
         fr(hi_pow, 1'b0, 16'h0, 1'b0);
         check(vad_flag, 1'b1);
      end
      fr(hi_pow, 1'b0, 16'h0, 1'b0);
      check(vad_flag, 1'b0);
   endtask
   task automatic t_high;
      lv = 16'h4000;
      repeat (20) fr(hi_pow, 1'b0, 16'h0, 1'b0);
      repeat (4) fr(hi_pow, 1'b1, 16'h0, 1'b0);
      repeat (7) begin
         fr(hi_pow, 1'b0, 16'h0, 1'b0);
         check(vad_flag, 1'b1);
      end
      fr(hi_pow, 1'b0, 16'h0, 1'b0);
      check(vad_flag, 1'b0);
      lv = 16'h0028;
   endtask
   task automatic t_complex;
      do_reset();
      repeat (100) fr(hi_pow, 1'b0, 16'h7000, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h00000064);
      check(complex_warning, 1'b1);
      fr(hi_pow, 1'b0, 16'h7000, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h04006365);
      apb(1'b0, 8'h04, 32'h0);
      check(rd[3:0], 4'hB);
      apb(1'b1, 8'h00, 32'h0);
      send(lo_pow, 1'b0, 16'h0, 1'b0);
      repeat (3) begin
         @(posedge pclk);
         check(frame_done, 1'b0);
      end
      check(vad_flag, 1'b1);
      apb(1'b1, 8'h00, 32'h1);
      fr(lo_pow, 1'b0, 16'h7000, 1'b1);
      check(vad_flag, 1'b0);
      apb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0);
   endtask
   task automatic t_quiet_corr;
      do_reset();
      fr(hi_pow, 1'b1, 16'h0, 1'b0);
      repeat (9) fr(hi_pow, 1'b0, 16'h0, 1'b0);
      fr(hi_pow, 1'b0, 16'h5800, 1'b0);
      check(vad_flag, 1'b0);
      fr(hi_pow, 1'b0, 16'h5800, 1'b0);
      check(vad_flag, 1'b1);
   endtask
   task automatic t_stat;
      do_reset();
      fr(hi_pow, 1'b0, 16'h0, 1'b0);
      fr(hi_pow, 1'b1, 16'h0, 1'b0);
      ptl = 3'b100;
      repeat (2) fr(hi_pow, 1'b1, 16'h0, 1'b0);
      apb(1'b0, 8'h04, 32'h0);
      check(rd[15:8], `VHN_STAT_INIT);
      ptl = 3'b001;
      repeat (14) fr(hi_pow, 1'b1, 16'h0, 1'b0);
      check(complex_warning, 1'b0);
      fr(hi_pow, 1'b1, 16'h0, 1'b0);
      check(complex_warning, 1'b1);
      repeat (2) fr(hi_pow, 1'b1, 16'h0, 1'b0);
      apb(1'b0, 8'h04, 32'h0);
      check(rd[15:8], `VHN_STAT_MIN_CX - 8'h01);
      ptl = 3'b010;
      repeat (5) fr(hi_pow, 1'b1, 16'h0, 1'b0);
      check(complex_warning, 1'b0);
      apb(1'b0, 8'h04, 32'h0);
      check(rd[15:8], `VHN_STAT_INIT);
      ptl = 3'b000;
      fr(hi_pow, 1'b1, 16'h0, 1'b0);
      lv = 16'h4000;
      fr(hi_pow, 1'b1, 16'h0, 1'b0);
      apb(1'b0, 8'h04, 32'h0);
      check(rd[15:8], `VHN_STAT_INIT);
      lv = 16'h0028;
   endtask
   // watchdog: whole run needs about 900 cycles
   initial begin
      #2000000;
      errors++;
      give_verdict();
   end
   initial begin
      do_reset();
      t_regs();
      t_burst();
      t_high();
      t_complex();
      t_quiet_corr();
      t_stat();
      give_verdict();
   end
endmodule // tb_top
